// file: inc/sgx_consts.svh
`ifndef SGX_CONSTS_SVH
`define SGX_CONSTS_SVH

// =========================================
// command codes (low three bits of command byte)
`define SGX_CMD_IN0 3'h0
`define SGX_CMD_IN1 3'h1
`define SGX_CMD_OUT0 3'h2
`define SGX_CMD_OUT1 3'h3
`define SGX_CMD_INV0 3'h4
`define SGX_CMD_INV1 3'h5
`define SGX_CMD_DIR0 3'h6
`define SGX_CMD_DIR1 3'h7

// =========================================
// reset values
`define SGX_OUT_RESET 8'hFF
`define SGX_INV_RESET 8'h00
`define SGX_DIR_RESET 8'hFF
`define SGX_CMD_RESET 8'h00

// =========================================
// field positions
`define SGX_RW_BIT 0
`define SGX_PAIR_BIT 0

`endif

// file: inc/sgx_pkg.sv
package sgx_pkg;

    // =========================================
    // serial slave states, gray along the write path
    typedef enum logic [2:0] {
        SGX_IDLE = 3'b000,
        SGX_ADDR = 3'b001,
        SGX_CMD = 3'b011,
        SGX_WDATA = 3'b010,
        SGX_RDATA = 3'b110,
        SGX_SKIP = 3'b111
    } sgx_state_type;

endpackage : sgx_pkg

// file: verilog/sgx_sync.sv
`timescale 1ns/1ps

// =========================================
// three-stage synchroniser with agreement filter
module sgx_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] clean
);
    logic [WIDTH-1:0] s1Reg;
    logic [WIDTH-1:0] s2Reg;
    logic [WIDTH-1:0] s3Reg;
    logic [WIDTH-1:0] cleanNext;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign cleanNext[i] = (s2Reg[i] == s3Reg[i]) ? s3Reg[i] : clean[i];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1Reg <= INIT;
            s2Reg <= INIT;
            s3Reg <= INIT;
            clean <= INIT;
        end else begin
            s1Reg <= async;
            s2Reg <= s1Reg;
            s3Reg <= s2Reg;
            clean <= cleanNext;
        end
    end
endmodule : sgx_sync

// file: verilog/sgx_expander.sv
`timescale 1ns/1ps
`include "sgx_consts.svh"

// Operation
// - input pins: both drivers off, pin high impedance
// - output pins: one driver on, level from output register bit
// - reset initialises registers and serial state machine
// - any edge on an input pin versus captured value raises interrupt
// - interrupt clears on return to old value or port read
// - read clear acts at acknowledge bit after serial clock rise
// - change during acknowledge pulse may be lost
// - after a clear, further changes raise interrupt again
// - output pins never cause interrupt; direction change may
// - write: start, address with write bit, command, data bytes
// - pointer toggles within its pair after each data byte
// - unlimited write bytes, only selected pair touched
// - read: command write, restart, address with read bit, data
// - pins sampled into input register at acknowledge clock rise
// - read bytes alternate within pair; master ends with nack
// - later start continues from pair partner of last read
// - read without command when pointer already selects input 0
// - stop may end transfer anywhere; last acknowledged data stands
// - low three bits of command select one of eight registers
// - input registers read only, writes ignored
// - inversion bit inverts stored input value
// - direction one is input, zero is output
module sgx_expander #(
    parameter int PINS = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [6:0] slaveAddr,
    input wire logic [PINS-1:0] pinIn,
    output logic [PINS-1:0] pinOut,
    output logic [PINS-1:0] pinOe,
    output logic highSideDriver,
    output logic intOut,
    output logic intOe,
    output logic busBusy
);
    // =========================================
    // link domain: serial slave on sclClk; sda sampled on rising edge
    logic sclReset_n1;
    logic sclReset_n;
    logic startSeen;
    logic stopSeen;
    logic sdaFallAck;
    logic startTgl;
    logic stopTgl;
    logic [1:0] startSyncS;
    logic [1:0] stopSyncS;
    logic sdaPrevReg;
    sgx_pkg::sgx_state_type stReg;
    logic [3:0] bitReg;
    logic [7:0] shReg;
    logic [7:0] txReg;
    logic ackPhase;
    logic ackReg;
    logic isRead;
    logic [7:0] cmdReg;
    logic [7:0] outReg [2];
    logic [7:0] invReg [2];
    logic [7:0] dirReg [2];
    logic [PINS-1:0] inRaw;
    logic [PINS-1:0] inCapReg;
    logic [1:0] readTgl;
    logic [1:0] sampleTgl;
    logic rdFirst;
    logic sdaEnReg;

    // start/stop are sda edges with scl high, caught on sda edges
    always_ff @(negedge sdaIn or negedge sclReset_n) begin
        if (!sclReset_n) begin
            startTgl <= 1'b0;
        end else if (sclClk) begin
            startTgl <= ~startTgl;
        end
    end

    always_ff @(posedge sdaIn or negedge sclReset_n) begin
        if (!sclReset_n) begin
            stopTgl <= 1'b0;
        end else if (sclClk) begin
            stopTgl <= ~stopTgl;
        end
    end

    // reset into link domain
    always_ff @(posedge sclClk) begin
        sclReset_n1 <= reset_n;
        sclReset_n <= sclReset_n1;
    end

    always_ff @(posedge sclClk) begin
        startSyncS <= {startSyncS[0], startTgl};
        stopSyncS <= {stopSyncS[0], stopTgl};
    end
    assign startSeen = startSyncS[1] != startSyncS[0];
    assign stopSeen = stopSyncS[1] != stopSyncS[0];

    wire [7:0] shNext = {shReg[6:0], sdaIn};
    wire byteDone = (bitReg == 4'd7) && (stReg != sgx_pkg::SGX_IDLE);
    wire [2:0] ptr = cmdReg[2:0];
    wire [2:0] ptrPartner = {ptr[2:1], ~ptr[`SGX_PAIR_BIT]};
    wire addrHit = shNext[7:1] == slaveAddr;
    wire [PINS-1:0] inView = inCapReg ^ {invReg[1], invReg[0]};

    function automatic logic [7:0] regRead(input logic [2:0] p, input logic [15:0] v);
        unique case (p[2:1])
            2'd0: regRead = p[0] ? v[15:8] : v[7:0];
            2'd1: regRead = outReg[p[0]];
            2'd2: regRead = invReg[p[0]];
            2'd3: regRead = dirReg[p[0]];
        endcase
    endfunction : regRead

    // =========================================
    // serial state machine, rising scl edge
    always_ff @(posedge sclClk) begin
        if (!sclReset_n) begin
            stReg <= sgx_pkg::SGX_IDLE;
            bitReg <= 4'd0;
            shReg <= 8'h00;
            ackPhase <= 1'b0;
            isRead <= 1'b0;
            cmdReg <= `SGX_CMD_RESET;
            outReg[0] <= `SGX_OUT_RESET;
            outReg[1] <= `SGX_OUT_RESET;
            invReg[0] <= `SGX_INV_RESET;
            invReg[1] <= `SGX_INV_RESET;
            dirReg[0] <= `SGX_DIR_RESET;
            dirReg[1] <= `SGX_DIR_RESET;
            inCapReg <= '0;
            readTgl <= 2'b00;
            sampleTgl <= 2'b00;
            rdFirst <= 1'b0;
        end else if (stopSeen) begin
            stReg <= sgx_pkg::SGX_IDLE;
            ackPhase <= 1'b0;
        end else if (startSeen) begin
            stReg <= sgx_pkg::SGX_ADDR;
            // start is seen one bit late: keep the first bit already shifted in
            bitReg <= 4'd2;
            shReg <= {6'h00, shReg[0], sdaIn};
            ackPhase <= 1'b0;
        end else if (ackPhase) begin
            ackPhase <= 1'b0;
            bitReg <= 4'd0;
            rdFirst <= 1'b0;
            if (stReg == sgx_pkg::SGX_RDATA) begin
                // ack clock rise: sample pins, clear on read, next byte
                inCapReg <= inRaw;
                sampleTgl[0] <= ~sampleTgl[0];
                if (!rdFirst) begin
                    if (ptr[2:1] == 2'd0) begin
                        readTgl[ptr[0]] <= ~readTgl[ptr[0]];
                    end
                    cmdReg <= {cmdReg[7:3], ptrPartner};
                    if (sdaIn) begin
                        stReg <= sgx_pkg::SGX_SKIP;
                    end
                end
            end
        end else begin
            shReg <= shNext;
            bitReg <= bitReg + 4'd1;
            if (byteDone) begin
                ackPhase <= 1'b1;
                unique case (stReg)
                    sgx_pkg::SGX_ADDR: begin
                        if (addrHit) begin
                            isRead <= shNext[`SGX_RW_BIT];
                            rdFirst <= shNext[`SGX_RW_BIT];
                            stReg <= shNext[0] ? sgx_pkg::SGX_RDATA : sgx_pkg::SGX_CMD;
                        end else begin
                            stReg <= sgx_pkg::SGX_SKIP;
                        end
                    end
                    sgx_pkg::SGX_CMD: begin
                        cmdReg <= shNext;
                        stReg <= sgx_pkg::SGX_WDATA;
                    end
                    sgx_pkg::SGX_WDATA: begin
                        unique case (ptr[2:1])
                            2'd0: ;
                            2'd1: outReg[ptr[0]] <= shNext;
                            2'd2: invReg[ptr[0]] <= shNext;
                            2'd3: dirReg[ptr[0]] <= shNext;
                        endcase
                        cmdReg <= {cmdReg[7:3], ptrPartner};
                    end
                    default: ;
                endcase
            end
        end
    end

    // =========================================
    // sda drive on falling scl
    wire isReadData = (stReg == sgx_pkg::SGX_RDATA);
    wire ackDrive = ackPhase && (stReg != sgx_pkg::SGX_SKIP) && (!isReadData || rdFirst);
    always_ff @(negedge sclClk) begin
        if (!sclReset_n) begin
            txReg <= 8'hFF;
            ackReg <= 1'b0;
        end else begin
            ackReg <= ackDrive;
            // release during ack so sda never moves while scl is high
            if (isReadData && ackPhase) begin
                txReg <= 8'hFF;
            end else if (isReadData && bitReg == 4'd0) begin
                txReg <= regRead(ptr, inView[15:0]);
            end else if (isReadData) begin
                txReg <= {txReg[6:0], 1'b1};
            end
        end
    end
    assign sdaFallAck = ackReg;
    assign sdaOut = 1'b0;
    assign sdaOe = sdaEnReg && (sdaFallAck || (isReadData && !txReg[7]));
    assign busBusy = stReg != sgx_pkg::SGX_IDLE;

    // =========================================
    // system domain: pins, interrupt
    logic [PINS-1:0] pinSync;
    logic [PINS-1:0] dirSys;
    logic [PINS-1:0] outSys;
    logic [1:0] readSys;
    logic [1:0] readPrevReg;
    logic [PINS-1:0] refReg;
    logic intReg;

    sgx_sync #(.WIDTH(PINS), .INIT('1)) u_pin_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async(pinIn),
        .clean(pinSync)
    );
    sgx_sync #(.WIDTH(2), .INIT('0)) u_read_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async(readTgl),
        .clean(readSys)
    );
    sgx_sync #(.WIDTH(PINS), .INIT('1)) u_dir_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async({dirReg[1], dirReg[0]}),
        .clean(dirSys)
    );
    sgx_sync #(.WIDTH(PINS), .INIT('1)) u_out_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async({outReg[1], outReg[0]}),
        .clean(outSys)
    );
    assign inRaw = pinIn;

    wire [1:0] readEv = readSys ^ readPrevReg;
    wire [PINS-1:0] readMask = {{8{readEv[1]}}, {8{readEv[0]}}};
    wire [PINS-1:0] refNext = (refReg & ~readMask) | (pinSync & readMask);
    wire [PINS-1:0] diffBits = (pinSync ^ refNext) & dirSys;
    wire intNext = |diffBits;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            readPrevReg <= 2'b00;
            sdaEnReg <= 1'b0;
            refReg <= '1;
            intReg <= 1'b0;
            pinOut <= '1;
            pinOe <= '0;
        end else begin
            readPrevReg <= readSys;
            sdaEnReg <= 1'b1;
            refReg <= refNext;
            intReg <= intNext;
            pinOut <= outSys;
            pinOe <= ~dirSys;
        end
    end
    assign highSideDriver = |(pinOe & pinOut);
    assign intOut = 1'b0;
    assign intOe = intReg;
endmodule : sgx_expander

// file: bench/sgx_expander_monitor.sv
`timescale 1ns/1ps

// ==========
// port checker
module sgx_expander_monitor #(
    parameter int PINS = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [PINS-1:0] pinIn,
    input wire logic [PINS-1:0] pinOut,
    input wire logic [PINS-1:0] pinOe,
    input wire logic highSideDriver,
    input wire logic intOut,
    input wire logic intOe,
    input wire logic busBusy
);
    logic [5:0] calm_reg;
    logic [5:0] busAge_reg;
    always_ff @(posedge clk) begin
        if (!reset_n || busBusy || $changed(pinOe) || |((pinIn ^ $past(pinIn)) & ~pinOe))
            calm_reg <= 6'h00;
        else if (calm_reg != 6'h3f)
            calm_reg <= calm_reg + 6'h01;
        if (!reset_n || busBusy)
            busAge_reg <= 6'h00;
        else if (busAge_reg != 6'h3f)
            busAge_reg <= busAge_reg + 6'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=>
        pinOe == '0 && pinOut == '1 && !intOe && !sdaOe) else $error("bad reset state");
    a_pin_drivers: assert property ($stable(pinOe) && $stable(pinOut) |->
        highSideDriver == |(pinOe & pinOut)) else $error("high side mismatch");
    a_open_drain: assert property (!intOut && !sdaOut) else $error("drive high");
    a_int_cause: assert property ($rose(intOe) |-> calm_reg < 6'h10)
        else $error("interrupt without cause");
    a_int_release: assert property ($fell(intOe) |-> calm_reg < 6'h10)
        else $error("interrupt cleared without cause");
    a_int_rearm: assert property (!intOe && !busBusy && calm_reg > 6'h10 &&
        $stable(pinOe) && |((pinIn ^ $past(pinIn)) & ~pinOe) |-> ##[1:12] intOe)
        else $error("input change missed");
    a_sda_quiet: assert property (!busBusy |-> !sdaOe) else $error("sda driven idle");
    a_dir_by_bus: assert property ($changed(pinOe) |-> busAge_reg < 6'h20)
        else $error("direction changed off bus");
    a_out_by_bus: assert property ($changed(pinOut) |-> busAge_reg < 6'h20)
        else $error("output changed off bus");
    cover property ($rose(intOe));
    cover property ($fell(intOe));
    cover property ($changed(pinOe));
endmodule : sgx_expander_monitor

bind sgx_expander sgx_expander_monitor #(.PINS(PINS)) mon (.clk, .reset_n, .sdaOut, .sdaOe,
    .pinIn, .pinOut, .pinOe, .highSideDriver, .intOut, .intOe, .busBusy);

// file: bench/sgx_bus_master.sv
`timescale 1ns/1ps

// ==========
// serial bus master, clock pulsed three times after stop, then held high between frames
module sgx_bus_master (
    output logic sclClk,
    output logic sdaLow,
    input wire logic sda
);
    initial begin
        sclClk = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        #16 sdaLow = !b;
        #16 sclClk = 1'b1;
        #16 r = sda;
        #16 sclClk = 1'b0;
    endtask : bit_io
    task automatic pulse(input int n);
        logic r;
        repeat (n) bit_io(1'b1, r);
        #16 sclClk = 1'b1;
    endtask : pulse
    task automatic start();
        sdaLow = 1'b0;
        #16 sclClk = 1'b1;
        #16 sdaLow = 1'b1;
        #16 sclClk = 1'b0;
    endtask : start
    task automatic stop();
        #16 sdaLow = 1'b1;
        #16 sclClk = 1'b1;
        #16 sdaLow = 1'b0;
        pulse(3);
    endtask : stop
    task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
        output logic ackOut);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ackIn, ackOut);
    endtask : xfer
endmodule : sgx_bus_master

// file: bench/tb_sgx_expander.sv
`timescale 1ns/1ps

// ==========
// testbench
module tb_sgx_expander;
    localparam logic [6:0] ADDR = 7'h27;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] ext = 16'hffff;
    logic sdaLow, sclClk, sdaOe, highSideDriver, intOe;
    logic [15:0] pinOut, pinOe;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] pinOut_unused;
    logic ackWrong;
    wire sdaIn = !(sdaLow || sdaOe);
    always #2 clk = ~clk;
    sgx_bus_master m (.sclClk(sclClk), .sdaLow(sdaLow), .sda(sdaIn));
    sgx_expander #(.PINS(16)) dut (.clk(clk), .reset_n(reset_n), .sclClk(sclClk),
        .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe), .slaveAddr(ADDR), .pinIn(ext),
        .pinOut(pinOut), .pinOe(pinOe), .highSideDriver(highSideDriver), .intOut(),
        .intOe(intOe), .busBusy());
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic head(input logic rd, input logic [7:0] cmd, input logic useCmd);
        logic [7:0] q;
        logic a;
        m.start();
        m.xfer({ADDR, !useCmd && rd}, 1'b1, q, a);
        chk({15'h0000, a}, 16'h0000);
        if (useCmd) m.xfer(cmd, 1'b1, q, a);
        if (useCmd && rd) begin
            m.start();
            m.xfer({ADDR, 1'b1}, 1'b1, q, a);
        end
    endtask : head
    task automatic wr(input logic [7:0] cmd, input logic [23:0] d, input int n);
        logic [7:0] q;
        logic a;
        head(1'b0, cmd, 1'b1);
        for (int i = 0; i < n; i++) m.xfer(d[8*i +: 8], 1'b1, q, a);
        m.stop();
    endtask : wr
    task automatic rd(input logic useCmd, input logic [7:0] cmd, input int n,
        input logic [23:0] exp);
        logic [7:0] q;
        logic a;
        head(1'b1, cmd, useCmd);
        for (int i = 0; i < n; i++) begin
            m.xfer(8'hff, i == n - 1, q, a);
            chk({8'h00, q}, {8'h00, exp[8*i +: 8]});
        end
        m.stop();
    endtask : rd
    task automatic wait_int(input logic v);
        int k;
        k = 0;
        while (intOe !== v && k < 50) begin
            @(posedge clk);
            k++;
        end
        chk({15'h0000, intOe}, {15'h0000, v});
    endtask : wait_int
    task automatic set_pins(input logic [15:0] v);
        @(posedge clk) #1 ext = v;
    endtask : set_pins
    initial begin
        fork
            m.pulse(2);
            repeat (6) @(posedge clk);
        join
        @(posedge clk) #1 reset_n = 1'b1;
        m.pulse(3);
        chk(pinOe, 16'h0000);
        chk(pinOut, 16'hffff);
        rd(1'b1, 8'h06, 2, 24'h00ffff);
        rd(1'b1, 8'h04, 2, 24'h000000);
        $display("test reset done");
        wr(8'h02, 24'h5a3ca5, 3);
        wr(8'h06, 24'h00f000, 2);
        set_pins(16'hfc5a);
        chk(pinOe, 16'h0fff);
        chk(pinOut & 16'h0fff, 16'h0c5a);
        chk({15'h0000, highSideDriver}, 16'h0001);
        wr(8'h00, 24'h000000, 2);
        rd(1'b1, 8'h02, 3, 24'h5a3c5a);
        wr(8'h04, 24'h000f00, 2);
        rd(1'b1, 8'h01, 2, 24'h005af3);
        rd(1'b0, 8'h00, 1, 24'h0000f3);
        $display("test registers done");
        set_pins(16'hfc5b);
        repeat (20) @(posedge clk);
        chk({15'h0000, intOe}, 16'h0000);
        set_pins(16'h7c5a);
        wait_int(1'b1);
        set_pins(16'hfc5a);
        wait_int(1'b0);
        set_pins(16'h7c5a);
        wait_int(1'b1);
        rd(1'b1, 8'h01, 1, 24'h000073);
        wait_int(1'b0);
        $display("test interrupt done");
        wr(8'h00, 24'h000000, 0);
        rd(1'b0, 8'h00, 1, 24'h00005a);
        m.start();
        m.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, pinOut_unused, ackWrong);
        chk({15'h0000, ackWrong}, 16'h0001);
        m.stop();
        $display("test addressing done");
        report_and_stop();
    end
endmodule : tb_sgx_expander
